// ==== verif/atr_tb.sv ====
// Self-checking bench for the antenna trim register block
`timescale 1ns/1ps
`default_nettype none
module testbench import atr_pkg::*;;
   logic clk = 1'b0;
   logic rst_n, psel, pen, pwr, sdef, cdone, kdone, pready, perr, irq, er;
   logic [11:0] addr;
   logic [31:0] wdata, prdata, rd;
   logic [7:0] cdata, phase;
   atr_cal_t cal;
   atr_trim_pins_t pins;
   logic [29:0] tab [0:12];
   int bad_count, n_tests, cyc, i;
   always #2.5 clk = ~clk;
   atr_regs dut_u (.i_clk_sys(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(perr), .i_set_default(sdef), .i_conv_done(cdone), .i_conv_data(cdata),
      .i_cal_done(kdone), .i_cal_result(cal), .o_phase_target(phase), .o_trim_pins(pins),
      .o_irq(irq));
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, {er, rd}, {1'b0, 24'h0, e});
   endtask
   task automatic ev(input logic [2:0] k);
      @(posedge clk);
      {sdef, kdone, cdone} <= k;
      @(posedge clk);
      {sdef, kdone, cdone} <= 3'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      // Rows: write, address, write data, expected read data, expected error
      tab = '{{1'b0, 12'h080, 8'h00, 8'h00, 1'b0}, {1'b0, 12'h084, 8'h00, 8'h00, 1'b0},
         {1'b0, 12'h088, 8'h00, 8'h80, 1'b0}, {1'b0, 12'h08c, 8'h00, 8'h00, 1'b0},
         {1'b1, 12'h084, 8'hff, 8'h00, 1'b0}, {1'b0, 12'h084, 8'h00, 8'hf8, 1'b0},
         {1'b1, 12'h088, 8'h5a, 8'h00, 1'b0}, {1'b0, 12'h088, 8'h00, 8'h5a, 1'b0},
         {1'b1, 12'h080, 8'h12, 8'h00, 1'b1}, {1'b1, 12'h08c, 8'h34, 8'h00, 1'b1},
         {1'b0, 12'h090, 8'h00, 8'h00, 1'b1}, {1'b0, 12'h081, 8'h00, 8'h00, 1'b1},
         {1'b0, 12'h0c4, 8'h00, 8'h00, 1'b0}};
      {rst_n, psel, pen, pwr, sdef, cdone, kdone} = 7'h0;
      addr = 12'h000;
      wdata = 32'h0;
      cdata = 8'ha5;
      cal = '{trim: 4'h6, err: 1'b1};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset phase", {25'h0, phase}, {25'h0, 8'h80});
      for (i = 0; i < 13; i++) begin
         apb(tab[i][29], tab[i][28:17], tab[i][16:9]);
         chk("table", {er, rd}, {tab[i][0], 24'h0, tab[i][8:1]});
      end
      chk("phase out", {25'h0, phase}, {25'h0, 8'h5a});
      chk("manual all", {25'h0, pins}, {25'h0, 8'hff});
      $display("table test done");
      ev(3'h1);
      rchk("conversion", 12'h080, 8'ha5);
      apb(1'b1, 12'h0c4, 8'h07);
      ev(3'h2);
      rchk("cal result", 12'h08c, 8'h68);
      apb(1'b1, 12'h084, 8'h00);
      repeat (2) @(posedge clk);
      chk("auto pins", {25'h0, pins}, {25'h0, 8'h66});
      apb(1'b1, 12'h084, 8'hd0);
      repeat (2) @(posedge clk);
      chk("manual pins", {25'h0, pins}, {25'h0, 8'haa});
      $display("trim test done");
      chk("irq set", {32'h0, irq}, 33'h1);
      rchk("status", 12'h0c0, 8'h07);
      apb(1'b1, 12'h0c0, 8'h07);
      apb(1'b1, 12'h0c4, 8'h00);
      ev(3'h1);
      chk("irq masked", {32'h0, irq}, 33'h0);
      rchk("status masked", 12'h0c0, 8'h01);
      $display("interrupt test done");
      ev(3'h4);
      rchk("default conv", 12'h080, 8'h00);
      rchk("default trim", 12'h084, 8'h00);
      rchk("default target", 12'h088, 8'h80);
      rchk("default cal", 12'h08c, 8'h00);
      chk("default pins", {25'h0, pins}, 33'h0);
      $display("restore defaults test done");
      test_done();
   end
endmodule
`default_nettype wire

// ==== verilog/atr_defines.svh ====
// Register map, field positions and reset values for the antenna trim registers
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH
// Register indices; byte address is four times the index
`define ATR_IDX_CONV_RESULT 8'h20
`define ATR_IDX_TRIM_CTRL 8'h21
`define ATR_IDX_PHASE_TARGET 8'h22
`define ATR_IDX_CAL_RESULT 8'h23
`define ATR_IDX_IRQ_STATUS 8'h30
`define ATR_IDX_IRQ_MASK 8'h31
// Field positions
`define ATR_TRIM_SRC_BIT 7
`define ATR_TRIM_MAN_MSB 6
`define ATR_TRIM_MAN_LSB 3
`define ATR_CAL_TRIM_MSB 7
`define ATR_CAL_TRIM_LSB 4
`define ATR_CAL_ERR_BIT 3
// Interrupt status bits
`define ATR_IRQ_CONV_BIT 0
`define ATR_IRQ_CAL_BIT 1
`define ATR_IRQ_ERR_BIT 2
// Reset values and trim control write mask
`define ATR_RST_CONV 8'h00
`define ATR_RST_TRIM_CTRL 8'h00
`define ATR_RST_PHASE_TARGET 8'h80
`define ATR_RST_CAL_RESULT 8'h00
`define ATR_TRIM_CTRL_WMASK 8'hf8
`endif

// ==== verilog/atr_pkg.sv ====
// Types shared by the antenna trim register block
package atr_pkg;
   typedef struct packed {
      logic [3:0] trim;
      logic err;
   } atr_cal_t;
   typedef struct packed {
      logic [3:0] group_one;
      logic [3:0] group_two;
   } atr_trim_pins_t;
endpackage

// ==== verilog/atr_regs.sv ====
// Antenna trim and conversion result register bank with APB slave
//
// Decided for this implementation: the APB interface to the registers.
`include "atr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module atr_regs
   import atr_pkg::*;
(
   input wire logic i_clk_sys, // 200 MHz system clock
   input wire logic i_arst_n, // Async reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [11:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic o_pready, // APB ready
   output logic [31:0] o_prdata, // APB read data
   output logic o_pslverr, // APB error
   input wire logic i_set_default, // Restore-defaults pulse
   input wire logic i_conv_done, // Conversion done pulse
   input wire logic [7:0] i_conv_data, // Conversion value
   input wire logic i_cal_done, // Calibration done pulse
   input wire atr_cal_t i_cal_result, // Calibration outcome
   output logic [7:0] o_phase_target, // Target phase to calibrator
   output atr_trim_pins_t o_trim_pins, // Trim switch drives
   output logic o_irq // Level interrupt
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic [7:0] conv_reg, conv_next;
   logic [7:0] trim_ctrl_reg, trim_ctrl_next;
   logic [7:0] target_reg, target_next;
   logic [7:0] cal_reg, cal_next;
   logic [2:0] irq_mask_reg, irq_mask_next;
   logic [2:0] irq_stat;
   logic [31:0] rdata_next;
   logic [3:0] trim_sel;
   wire acc = i_psel && i_penable && !o_pready;
   // Writes land at the edge where the master sees pready high
   wire wr = i_psel && i_penable && o_pready && i_pwrite;
   wire [9:0] idx = i_paddr[11:2];
   wire hit_conv = idx == {2'b00, `ATR_IDX_CONV_RESULT};
   wire hit_trim = idx == {2'b00, `ATR_IDX_TRIM_CTRL};
   wire hit_tgt = idx == {2'b00, `ATR_IDX_PHASE_TARGET};
   wire hit_cal = idx == {2'b00, `ATR_IDX_CAL_RESULT};
   wire hit_stat = idx == {2'b00, `ATR_IDX_IRQ_STATUS};
   wire hit_mask = idx == {2'b00, `ATR_IDX_IRQ_MASK};
   wire mapped = hit_conv | hit_trim | hit_tgt | hit_cal | hit_stat | hit_mask;
   wire aligned = i_paddr[1:0] == 2'b00;
   wire bad = !mapped || !aligned || (i_pwrite && (hit_conv || hit_cal));
   wire wr_ok = wr && !bad;

   // ----------------------------------------
   // Register next values
   // ----------------------------------------
   // latest conversion
   assign conv_next = i_set_default ? `ATR_RST_CONV : (i_conv_done ? i_conv_data : conv_reg);
   assign trim_ctrl_next = i_set_default ? `ATR_RST_TRIM_CTRL :
      ((wr_ok && hit_trim) ? (i_pwdata[7:0] & `ATR_TRIM_CTRL_WMASK) : trim_ctrl_reg);
   assign target_next = i_set_default ? `ATR_RST_PHASE_TARGET :
      ((wr_ok && hit_tgt) ? i_pwdata[7:0] : target_reg);
   // result and error as one word
   assign cal_next = i_set_default ? `ATR_RST_CAL_RESULT :
      (i_cal_done ? {i_cal_result.trim, i_cal_result.err, 3'b000} : cal_reg);
   assign irq_mask_next = (wr_ok && hit_mask) ? i_pwdata[2:0] : irq_mask_reg;
   assign trim_sel = trim_ctrl_reg[`ATR_TRIM_SRC_BIT] ?
      trim_ctrl_reg[`ATR_TRIM_MAN_MSB:`ATR_TRIM_MAN_LSB] :
      cal_reg[`ATR_CAL_TRIM_MSB:`ATR_CAL_TRIM_LSB];
   assign rdata_next = !i_pwrite && !bad ? {24'h000000,
      ({8{hit_conv}} & conv_reg) | ({8{hit_trim}} & trim_ctrl_reg) |
      ({8{hit_tgt}} & target_reg) | ({8{hit_cal}} & cal_reg) |
      ({8{hit_stat}} & {5'h00, irq_stat}) | ({8{hit_mask}} & {5'h00, irq_mask_reg})} : 32'h0;

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   wire [2:0] ev = {i_cal_done && i_cal_result.err, i_cal_done, i_conv_done};
   wire [2:0] clr = (wr_ok && hit_stat) ? i_pwdata[2:0] : 3'b000;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_irq
         atr_sticky_bit u_bit (
            .i_clk_sys(i_clk_sys),
            .i_arst_n(i_arst_n),
            .i_set(ev[g]),
            .i_clr(clr[g]),
            .o_flag(irq_stat[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Flip-flops
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         conv_reg <= `ATR_RST_CONV;
         trim_ctrl_reg <= `ATR_RST_TRIM_CTRL;
         target_reg <= `ATR_RST_PHASE_TARGET;
         cal_reg <= `ATR_RST_CAL_RESULT;
         irq_mask_reg <= 3'h0;
      end else begin
         conv_reg <= conv_next;
         trim_ctrl_reg <= trim_ctrl_next;
         target_reg <= target_next;
         cal_reg <= cal_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= acc;
         o_pslverr <= acc && bad;
         if (acc) begin
            o_prdata <= rdata_next;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_trim_pins <= '0;
         o_phase_target <= `ATR_RST_PHASE_TARGET;
         o_irq <= 1'b0;
      end else begin
         o_trim_pins <= {trim_sel, trim_sel};
         o_phase_target <= target_reg;
         o_irq <= |(irq_stat & irq_mask_reg);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   AST_CONV_CAPTURE: assert property (
      i_conv_done && !i_set_default |=> conv_reg == $past(i_conv_data))
      else $error("conversion result not captured");
   AST_DEFAULT_CLEAR: assert property (
      i_set_default |=> conv_reg == 8'h00 && cal_reg == 8'h00)
      else $error("results not cleared by restore-defaults");
   AST_DEFAULT_LOAD: assert property (
      i_set_default |=> trim_ctrl_reg == 8'h00 && target_reg == 8'h80)
      else $error("defaults not loaded");
   AST_MANUAL_TRIM: assert property (
      trim_ctrl_reg[7] |=> o_trim_pins.group_one == $past(trim_ctrl_reg[6:3])
         && o_trim_pins.group_two == $past(trim_ctrl_reg[6:3]))
      else $error("manual trim not driven");
   AST_AUTO_TRIM: assert property (
      !trim_ctrl_reg[7] |=> o_trim_pins.group_one == $past(cal_reg[7:4])
         && o_trim_pins.group_two == $past(cal_reg[7:4]))
      else $error("calibration trim not driven");
   AST_TARGET_OUT: assert property (
      wr_ok && hit_tgt && !i_set_default |=> ##1 o_phase_target == $past(i_pwdata[7:0], 2))
      else $error("phase target not applied");
   AST_CAL_PAIR: assert property (
      i_cal_done && !i_set_default |=> cal_reg[7:4] == $past(i_cal_result.trim)
         && cal_reg[3] == $past(i_cal_result.err))
      else $error("calibration pair not stored together");
   AST_LOW_ZERO: assert property (
      trim_ctrl_reg[2:0] == 3'b000 && cal_reg[2:0] == 3'b000)
      else $error("unused bits not zero");
   AST_RO_WRITE: assert property (
      acc && i_pwrite && (hit_cal || hit_conv) |=> o_pready && o_pslverr)
      else $error("read-only write not refused");
   AST_ERR_FLAG: assert property (
      i_cal_done && i_cal_result.err && !i_set_default |=> cal_reg[3] ##1 irq_stat[2])
      else $error("calibration error flag missing");
   AST_SRC_SEL: assert property (
      wr_ok && hit_trim && !i_set_default |=> trim_ctrl_reg[7] == $past(i_pwdata[7]))
      else $error("source select not written");

   COV_MANUAL: cover property (wr_ok && hit_trim && i_pwdata[7]);
   COV_CAL_ERR: cover property (i_cal_done && i_cal_result.err);
   COV_IRQ: cover property (o_irq);
   COV_SLVERR: cover property (o_pslverr);
endmodule
`default_nettype wire

// ==== verilog/atr_sticky_bit.sv ====
// One sticky interrupt status bit, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module atr_sticky_bit (
   input wire logic i_clk_sys, // System clock
   input wire logic i_arst_n, // Async reset, active low
   input wire logic i_set, // Event pulse
   input wire logic i_clr, // Write-one-to-clear
   output logic o_flag // Sticky flag
);
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire
